// [design/fmap_slot_mapper.sv]
// Flexible TDM byte-slot mapper for two input and two output data pins,
// with an AHB-Lite register slave and a link side on the bit clock.
// Assumes frame_sync and the data pins are timed by bit_clock, and that
// channels 32..47 are exchanged in parallel on the system clock.
//
// Notes on behaviour
// R01: Input channel position picks channel 0..7.
// R02: Each channel is four bytes; bits 1..0.
// R03: Byte code 00 is bits 31..24.
// R04: Sixty-four output slot entries, one byte each; the code keeps 16 bits per entry and uses the low byte.
// R05: Slots 0..31 second pin, 32..63 third.
// R06: Low six bits choose source channel byte.
// R07: Disabled slot with option set: high impedance.
// R08: Disabled slot with option clear: drive low.
// R09: Enabled slot drives selected byte on pin.
// R10: Entries at consecutive indices, reset to zero.
// R11: Input byte taken only when slot enabled.
// R12: Pin select picks channels 32..39 or 40..47.
// R13: Reverse option sends byte LSB first.
// R14: Group bit picks source channels 32..39 or 40..47.
// R15: Slots ascend in frame, eight bits each.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
module fmap_slot_mapper
	import fmap_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [CHAN_COUNT-1:0][31:0] out_chan,
	output logic [CHAN_COUNT-1:0][31:0] in_chan,
	output logic in_frame_strobe,
	input wire logic bit_clock,
	input wire logic frame_sync,
	input wire logic serial_data_in_second,
	input wire logic serial_data_in_third,
	output logic serial_data_out_second,
	output logic serial_data_out_second_oe,
	output logic serial_data_out_third,
	output logic serial_data_out_third_oe
);

	fmap_sys_t s_q;
	fmap_sys_t s_d;
	fmap_link_t l_q;
	fmap_link_t l_d;

	logic [1:0] to_sys;
	logic [1:0] at_sys;
	logic [2:0] to_link;
	logic [2:0] at_link;
	logic req_s;
	logic tog_s;
	logic ack_s;
	logic [1:0] hiz_s;

	// Crossings: toggles one way, the ack toggle and option levels back
	assign to_sys = {l_q.req, l_q.in_tog};
	assign req_s = at_sys[1];
	assign tog_s = at_sys[0];
	assign to_link = {s_q.ack, s_q.hiz};
	assign ack_s = at_link[2];
	assign hiz_s = at_link[1:0];

	fmap_sync #(.WIDTH(2)) u_sync_sys
	(
		.clock(clock),
		.rst_b(rst_b),
		.async_in(to_sys),
		.sync_out(at_sys)
	);

	fmap_sync #(.WIDTH(3)) u_sync_link
	(
		.clock(bit_clock),
		.rst_b(rst_b),
		.async_in(to_link),
		.sync_out(at_link)
	);

	// Kinds of register word seen on the bus
	typedef enum logic [2:0]
	{
		FMAP_REG_NONE,
		FMAP_REG_IN_MAP,
		FMAP_REG_OUT_MAP,
		FMAP_REG_CTRL,
		FMAP_REG_STAT
	} fmap_reg_t;

	// Word decode shared by the write and read paths
	function automatic fmap_reg_t reg_decode(input logic [15:0] idx);
		fmap_reg_t k;
		k = FMAP_REG_NONE;
		if (fmap_in_block(idx, IN_MAP_BASE))
			k = FMAP_REG_IN_MAP;
		else if (fmap_in_block(idx, OUT_MAP_BASE))
			k = FMAP_REG_OUT_MAP;
		else if (idx == CTRL_IDX)
			k = FMAP_REG_CTRL;
		else if (idx == STAT_IDX)
			k = FMAP_REG_STAT;
		return k;
	endfunction

	function automatic logic [31:0] reg_read(input fmap_sys_t s,
		input logic [15:0] idx);
		logic [31:0] v;
		v = '0;
		// Map entries sit at consecutive word indices
		// R10: entry lookup
		case (reg_decode(idx))
			FMAP_REG_IN_MAP:
				v = 32'(s.in_map[idx[MAP_IDX_W-1:0]]);
			FMAP_REG_OUT_MAP:
				v = 32'(s.out_map[idx[MAP_IDX_W-1:0]]);
			FMAP_REG_CTRL:
				v = 32'(s.hiz);
			FMAP_REG_STAT:
				v = 32'(s.frames);
			default:
				v = '0;
		endcase
		return v;
	endfunction

	// System side: register slave and the two word handshakes
	always_comb
	begin
		logic sel;
		logic hi_ok;
		logic [15:0] idx;
		sel = hsel & hready & htrans[1];
		hi_ok = (haddr[31:ADDR_IDX_MSB+1] == '0);
		idx = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
		s_d = s_q;
		s_d.frame_stb = 1'b0;

		// Data phase of a write; status and unmapped words ignore it
		if (s_q.wr_pend)
		begin
			case (reg_decode(s_q.wr_idx))
				FMAP_REG_IN_MAP:
					s_d.in_map[s_q.wr_idx[MAP_IDX_W-1:0]] = hwdata[15:0];
				// R04: sixty-four output entries
				FMAP_REG_OUT_MAP:
					s_d.out_map[s_q.wr_idx[MAP_IDX_W-1:0]] = hwdata[15:0];
				FMAP_REG_CTRL:
				begin
					s_d.hiz[0] = hwdata[CTRL_HIZ2_BIT];
					s_d.hiz[1] = hwdata[CTRL_HIZ3_BIT];
				end
				default:
				begin
				end
			endcase
		end

		// Address phase; only whole words are expected, so size is unused
		s_d.wr_pend = sel & hwrite & hi_ok;
		s_d.wr_idx = idx;
		// Read from the next state so a write just before is seen
		if (sel & ~hwrite)
		begin
			if (hi_ok)
				s_d.rdata = reg_read(s_d, idx);
			else
				s_d.rdata = '0;
		end

		// Link asks for a fresh snapshot at a frame start once the last one was answered
		if (req_s != s_q.ack)
		begin
			s_d.sh_out_chan = out_chan;
			for (int i = 0; i < MAP_COUNT; i++)
			begin
				s_d.sh_in_map[i] = s_d.in_map[i][7:0];
				s_d.sh_out_map[i] = s_d.out_map[i][7:0];
			end
			s_d.ack = req_s;
		end

		// Hold words are stable for a whole frame after the toggle
		if (tog_s != s_q.tog_seen)
		begin
			s_d.tog_seen = tog_s;
			s_d.in_chan = l_q.hold;
			s_d.frame_stb = 1'b1;
			s_d.frames = s_q.frames + FRAME_STEP;
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// R10: all entries start disabled
			s_q <= '0;
			for (int i = 0; i < MAP_COUNT; i++)
			begin
				s_q.in_map[i] <= MAP_RESET;
				s_q.out_map[i] <= MAP_RESET;
			end
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign hrdata = s_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign in_chan = s_q.in_chan;
	assign in_frame_strobe = s_q.frame_stb;

	// Link side: slot sequencing, capture and transmit on the bit clock
	always_comb
	begin
		logic [4:0] slot;
		logic [7:0] e;
		logic [7:0] b;
		logic [31:0] w;
		logic [2:0] bidx;
		slot = l_q.bit_pos[7:3];
		e = '0;
		b = '0;
		w = '0;
		bidx = '0;
		l_d = l_q;

		if (l_q.active)
		begin
			l_d.sr2 = {l_q.sr2[6:0], serial_data_in_second};
			l_d.sr3 = {l_q.sr3[6:0], serial_data_in_third};
			// Each byte slot completes on its eighth bit
			if (l_q.bit_pos[2:0] == SLOT_LAST_BIT)
			begin
				for (int k = 0; k < 2; k++)
				begin
					e = l_q.w_in_map[{k[0], slot}];
					// R11: disabled slots are dropped
					if (e[SLOT_EN_BIT])
					begin
						// R12: pin select chooses stream
						if (e[PIN_SEL_BIT])
							b = l_d.sr3;
						else
							b = l_d.sr2;
						if (e[REV_BIT])
							b = fmap_rev8(b);
						// R01: channel position decode
						// R02: byte lane placement
						// R03: code 00 is top byte
						l_d.assembly[fmap_chan(e)][fmap_lane_lsb(e) +: 8] = b;
					end
				end
			end
			if (l_q.bit_pos == FRAME_LAST_BIT)
			begin
				l_d.hold = l_d.assembly;
				l_d.in_tog = ~l_q.in_tog;
			end
		end

		// R15: ascending slots of eight bits
		if (frame_sync)
		begin
			l_d.active = 1'b1;
			l_d.bit_pos = '0;
			// Take the snapshot only once the last one was answered;
			// a late answer keeps the previous maps for one more frame,
			// so the pins never see a half-copied set of entries
			if (ack_s == l_q.req)
			begin
				l_d.w_out_chan = s_q.sh_out_chan;
				l_d.w_in_map = s_q.sh_in_map;
				l_d.w_out_map = s_q.sh_out_map;
				l_d.req = ~l_q.req;
			end
		end
		else
		begin
			l_d.bit_pos = l_q.bit_pos + BIT_STEP;
		end

		// Outputs for the bit now starting; before any frame, let go
		bidx = l_d.bit_pos[2:0];
		for (int p = 0; p < 2; p++)
		begin
			// R05: slot half by pin
			e = l_d.w_out_map[{p[0], l_d.bit_pos[7:3]}];
			// R06: source from low six bits
			// R14: group and position pick channel
			w = l_d.w_out_chan[fmap_chan(e)];
			b = w[fmap_lane_lsb(e) +: 8];
			if (!l_d.active)
			begin
				l_d.dout[p] = 1'b0;
				l_d.oe[p] = 1'b0;
			end
			else if (e[SLOT_EN_BIT])
			begin
				// R09: drive selected byte
				// R13: reversed sends LSB first
				if (e[REV_BIT])
					l_d.dout[p] = b[bidx];
				else
					l_d.dout[p] = b[~bidx];
				l_d.oe[p] = 1'b1;
			end
			else
			begin
				// The option lags a control write by a few bit clocks
				// R07: released when option set
				// R08: driven low when clear
				l_d.dout[p] = 1'b0;
				l_d.oe[p] = ~hiz_s[p];
			end
		end
	end

	always_ff @(posedge bit_clock or negedge rst_b)
	begin
		if (!rst_b)
			l_q <= '0;
		else
			l_q <= l_d;
	end

	assign serial_data_out_second = l_q.dout[0];
	assign serial_data_out_second_oe = l_q.oe[0];
	assign serial_data_out_third = l_q.dout[1];
	assign serial_data_out_third_oe = l_q.oe[1];

endmodule

// [design/fmap_pkg.sv]
// Constants, state types and field decoders of the flexible TDM slot mapper.
// Assumes a 32-bit AHB-Lite register bus and a bit clock owned by the
// serial ports; shared by the mapper, its port checker and the bench.
package fmap_pkg;

	// Register word indices; byte address is four times the index
	localparam logic [15:0] IN_MAP_BASE = 16'hf300;
	localparam logic [15:0] OUT_MAP_BASE = 16'hf380;
	localparam logic [15:0] CTRL_IDX = 16'hf3c0;
	localparam logic [15:0] STAT_IDX = 16'hf3c1;
	localparam int ADDR_IDX_LSB = 2;
	localparam int ADDR_IDX_MSB = 17;
	localparam int MAP_IDX_W = 6;
	localparam logic [15:0] MAP_RESET = 16'h0000;

	// Slot map entry fields
	localparam int SLOT_EN_BIT = 7;
	localparam int REV_BIT = 6;
	localparam int PIN_SEL_BIT = 5;
	localparam int CHAN_POS_LSB = 2;
	localparam int BYTE_POS_LSB = 0;

	// Control register fields: high-impedance option per output pin
	localparam int CTRL_HIZ2_BIT = 0;
	localparam int CTRL_HIZ3_BIT = 1;

	// Frame geometry: eight 32-bit channels per pin, 32 byte slots
	localparam int MAP_COUNT = 64;
	localparam int CHAN_COUNT = 16;
	localparam logic [7:0] FRAME_LAST_BIT = 8'hff;
	localparam logic [2:0] SLOT_LAST_BIT = 3'h7;
	localparam logic [7:0] BIT_STEP = 8'h01;
	localparam logic [15:0] FRAME_STEP = 16'h0001;
	localparam logic HRESP_OKAY = 1'b0;

	typedef struct packed {
		logic [MAP_COUNT-1:0][15:0] in_map;
		logic [MAP_COUNT-1:0][15:0] out_map;
		logic [1:0] hiz;
		logic [15:0] frames;
		logic wr_pend;
		logic [15:0] wr_idx;
		logic [31:0] rdata;
		logic [CHAN_COUNT-1:0][31:0] in_chan;
		logic frame_stb;
		logic [CHAN_COUNT-1:0][31:0] sh_out_chan;
		logic [MAP_COUNT-1:0][7:0] sh_in_map;
		logic [MAP_COUNT-1:0][7:0] sh_out_map;
		logic ack;
		logic tog_seen;
	} fmap_sys_t;

	typedef struct packed {
		logic active;
		logic [7:0] bit_pos;
		logic [7:0] sr2;
		logic [7:0] sr3;
		logic [CHAN_COUNT-1:0][31:0] assembly;
		logic [CHAN_COUNT-1:0][31:0] hold;
		logic in_tog;
		logic req;
		logic [CHAN_COUNT-1:0][31:0] w_out_chan;
		logic [MAP_COUNT-1:0][7:0] w_in_map;
		logic [MAP_COUNT-1:0][7:0] w_out_map;
		logic [1:0] dout;
		logic [1:0] oe;
	} fmap_link_t;

	// Channel index 0..15 (channels 32..47) from group and position
	function automatic logic [3:0] fmap_chan(input logic [7:0] e);
		return {e[PIN_SEL_BIT], e[CHAN_POS_LSB +: 3]};
	endfunction

	// Low bit of the chosen byte lane: code 00 is bits 31..24
	function automatic logic [4:0] fmap_lane_lsb(input logic [7:0] e);
		return {~e[BYTE_POS_LSB +: 2], 3'h0};
	endfunction

	function automatic logic [7:0] fmap_rev8(input logic [7:0] b);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++)
			r[i] = b[7 - i];
		return r;
	endfunction

	function automatic logic fmap_in_block(input logic [15:0] idx,
		input logic [15:0] base);
		return idx[15:MAP_IDX_W] == base[15:MAP_IDX_W];
	endfunction

endpackage

// [design/fmap_sync.sv]
// Two-flop synchroniser for levels and toggles entering a clock domain.
// Assumes each bit is a level or a toggle that holds for several clocks.
`timescale 1ns/10ps
module fmap_sync
#(
	parameter int WIDTH = 1
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} fmap_sync_state_t;

	fmap_sync_state_t st_q;
	fmap_sync_state_t st_d;

	// Only the second stage is visible outside
	always_comb
	begin
		st_d.meta = async_in;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign sync_out = st_q.stable;

endmodule

// [testbench/fmap_slot_mapper_sva.sv]
// Port checker of the slot mapper.
// Assumes hready is tied to hreadyout and frames repeat.
`timescale 1ns/10ps
module fmap_slot_mapper_sva
	import fmap_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic hready,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [CHAN_COUNT-1:0][31:0] in_chan,
	input wire logic in_frame_strobe,
	input wire logic bit_clock,
	input wire logic frame_sync,
	input wire logic serial_data_out_second_oe,
	input wire logic serial_data_out_third_oe
);
	logic seen_q;
	logic [8:0] gap_q;
	sequence s_next_frame;
		##[310:330] in_frame_strobe;
	endsequence
	always_ff @(posedge bit_clock or negedge rst_b)
		if (!rst_b)
			seen_q <= 1'b0;
		else if (frame_sync)
			seen_q <= 1'b1;
	// Saturates so the first strobe after reset is never judged
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b)
			gap_q <= 9'h1ff;
		else if (in_frame_strobe)
			gap_q <= 9'h000;
		else if (gap_q != 9'h1ff)
			gap_q <= gap_q + 9'h001;
	a_bus_ready: assert property (@(posedge clock) disable iff (!rst_b)
		hreadyout) else $error("hreadyout low");
	a_resp_okay: assert property (@(posedge clock) disable iff (!rst_b)
		hresp == HRESP_OKAY) else $error("hresp not okay");
	a_upper_zero: assert property (@(posedge clock) disable iff (!rst_b)
		hrdata[31:16] == 16'h0000) else $error("hrdata upper set");
	a_rdata_hold: assert property (@(posedge clock) disable iff (!rst_b)
		$changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
		else $error("hrdata moved without read");
	a_chan_hold: assert property (@(posedge clock) disable iff (!rst_b)
		$changed(in_chan) |-> in_frame_strobe) else $error("in_chan moved");
	a_frame_period: assert property (@(posedge clock) disable iff (!rst_b)
		in_frame_strobe |-> s_next_frame) else $error("frame period off");
	a_strobe_gap: assert property (@(posedge clock) disable iff (!rst_b)
		in_frame_strobe |-> gap_q >= 9'h12c) else $error("strobe too soon");
	a_pins_idle: assert property (@(posedge bit_clock) disable iff (!rst_b)
		!seen_q |-> !serial_data_out_second_oe && !serial_data_out_third_oe)
		else $error("pin driven before frame");
endmodule
bind fmap_slot_mapper fmap_slot_mapper_sva i_sva (.clock(clock),
	.rst_b(rst_b), .hsel(hsel), .hready(hready), .htrans(htrans),
	.hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .in_chan(in_chan), .in_frame_strobe(in_frame_strobe),
	.bit_clock(bit_clock), .frame_sync(frame_sync),
	.serial_data_out_second_oe(serial_data_out_second_oe),
	.serial_data_out_third_oe(serial_data_out_third_oe));

// [testbench/fmap_tdm_model.sv]
// Far-side TDM device: frame sync, input bytes, output capture.
// Assumes a free-running bit clock; frames of 256 bits repeat.
`timescale 1ns/10ps
module fmap_tdm_model
(
	input wire logic bit_clock,
	input wire logic rst_b,
	output logic frame_sync,
	output logic din_second,
	output logic din_third,
	input wire logic dout_second,
	input wire logic oe_second,
	input wire logic dout_third,
	input wire logic oe_third
);
	logic [7:0] cnt_q, nx, b2, b3;
	logic [7:0] cap2[32], en2[32], cap3[32], en3[32];
	assign nx = cnt_q + 8'h01;
	// Slot number in the low bits tells the bytes apart
	assign b2 = {3'h5, nx[7:3]};
	assign b3 = {3'h2, nx[7:3]};
	always @(posedge bit_clock or negedge rst_b)
		if (!rst_b)
		begin
			cnt_q <= 8'h00;
			frame_sync <= 1'b0;
			din_second <= 1'b0;
			din_third <= 1'b0;
		end
		else
		begin
			cnt_q <= nx;
			frame_sync <= nx == 8'hff;
			din_second <= b2[~nx[2:0]];
			din_third <= b3[~nx[2:0]];
			cap2[cnt_q[7:3]][~cnt_q[2:0]] <= dout_second;
			en2[cnt_q[7:3]][~cnt_q[2:0]] <= oe_second;
			cap3[cnt_q[7:3]][~cnt_q[2:0]] <= dout_third;
			en3[cnt_q[7:3]][~cnt_q[2:0]] <= oe_third;
		end
endmodule

// [testbench/test_flexible_tdm_slot_mapper.sv]
// Bench of the slot mapper: AHB register tasks and TDM frames.
// Assumes the far side is fmap_tdm_model.
`timescale 1ns/10ps
module test_flexible_tdm_slot_mapper;
	logic clock = 1'b0;
	logic bit_clock = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, in_frame_strobe, frame_sync;
	logic din2, din3, do2, oe2, do3, oe3;
	logic [fmap_pkg::CHAN_COUNT-1:0][31:0] out_chan, in_chan;
	int num_errors = 0;
	int total_checks = 0;
	always #50 clock = ~clock;
	always #62.5 bit_clock = ~bit_clock;
	fmap_slot_mapper i_dut (.clock(clock), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .out_chan(out_chan),
		.in_chan(in_chan), .in_frame_strobe(in_frame_strobe),
		.bit_clock(bit_clock), .frame_sync(frame_sync),
		.serial_data_in_second(din2), .serial_data_in_third(din3),
		.serial_data_out_second(do2), .serial_data_out_second_oe(oe2),
		.serial_data_out_third(do3), .serial_data_out_third_oe(oe3));
	fmap_tdm_model i_model (.bit_clock(bit_clock), .rst_b(rst_b),
		.frame_sync(frame_sync), .din_second(din2), .din_third(din3),
		.dout_second(do2), .oe_second(oe2), .dout_third(do3),
		.oe_third(oe3));
	task automatic stop_test;
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] exp, got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Bounded wait for a condition sampled at rising edges
	task automatic wait_for(input int lim, input bit strobe);
		int n;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while ((strobe ? in_frame_strobe : hreadyout) !== 1'b1 && n < lim);
		if ((strobe ? in_frame_strobe : hreadyout) !== 1'b1)
		begin
			num_errors++;
			stop_test;
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_for(20, 1'b0);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_for(20, 1'b0);
		rd = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask
	task automatic rdc(input string nm, input logic [31:0] a, exp);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		check(nm, exp, r);
	endtask
	function automatic logic [31:0] oa(input logic [15:0] idx);
		return {14'h0, idx, 2'h0};
	endfunction
	initial
	begin
		for (int i = 0; i < 16; i++)
			out_chan[i] = {4'h1, 4'(i), 4'h2, 4'(i), 4'h3, 4'(i), 4'h4, 4'(i)};
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		rdc("out_map0", oa(fmap_pkg::OUT_MAP_BASE), 32'h0);
		rdc("out_map63", oa(fmap_pkg::OUT_MAP_BASE + 16'd63), 32'h0);
		wr(oa(fmap_pkg::OUT_MAP_BASE + 16'd63), 32'hffffffff);
		rdc("out_map63", oa(fmap_pkg::OUT_MAP_BASE + 16'd63), 32'hffff);
		rdc("unmapped", 32'h00040000, 32'h0);
		wr(oa(fmap_pkg::CTRL_IDX), 32'h1);
		wr(oa(fmap_pkg::OUT_MAP_BASE), 32'h84);
		wr(oa(fmap_pkg::OUT_MAP_BASE + 16'd1), 32'hff);
		wr(oa(fmap_pkg::OUT_MAP_BASE + 16'd2), 32'h04);
		wr(oa(fmap_pkg::OUT_MAP_BASE + 16'd32), 32'h8a);
		wr(oa(fmap_pkg::OUT_MAP_BASE + 16'd63), 32'h83);
		for (int p = 0; p < 8; p++)
			wr(oa(fmap_pkg::OUT_MAP_BASE + 16'(8 + p)), 32'(8'h80 + p * 5 - p / 4 * 4));
		wr(oa(fmap_pkg::IN_MAP_BASE), 32'h8d);
		wr(oa(fmap_pkg::IN_MAP_BASE + 16'd5), 32'h0f);
		wr(oa(fmap_pkg::IN_MAP_BASE + 16'd33), 32'ha0);
		wr(oa(fmap_pkg::IN_MAP_BASE + 16'd38), 32'hfe);
		repeat (4) wait_for(800, 1'b1);
		check("slot0", 32'(i_model.cap2[0]), 32'h11);
		check("slot0_oe", 32'(i_model.en2[0]), 32'hff);
		check("slot1", 32'(i_model.cap2[1]), 32'hf2);
		check("slot2_oe", 32'(i_model.en2[2]), 32'h0);
		check("slot32", 32'(i_model.cap3[0]), 32'h32);
		check("slot33", 32'(i_model.cap3[1]), 32'h0);
		check("slot33_oe", 32'(i_model.en3[1]), 32'hff);
		check("slot63", 32'(i_model.cap3[31]), 32'h40);
		for (int p = 0; p < 8; p++)
			check("pos", 32'(i_model.cap2[8 + p]), 32'(p % 4 * 16 + 16 + p));
		check("in_ch35", 32'(in_chan[3][23:16]), 32'ha0);
		check("in_ch40", 32'(in_chan[8][31:24]), 32'h41);
		check("in_ch35_lo", 32'(in_chan[3][7:0]), 32'h0);
		check("in_ch47", 32'(in_chan[15][15:8]), 32'h62);
		check("in_ch35_word", in_chan[3], 32'h00a00000);
		rdc("frames", oa(fmap_pkg::STAT_IDX), 32'h4);
		stop_test;
	end
endmodule
